//--- rtl/fws_host.sv
// Contract
// RULE1 - Two consecutive reads compare the toggle bit.
// RULE2 - Toggle steady means done, data valid.
// RULE3 - Toggling with fail flag high: recheck once; a window check (CTRL_CHECK) ends on the first toggle without a recheck.
// RULE4 - Still toggling after fail: write reset.
// RULE5 - Abandoned polling restarts from first read.
// RULE6 - Device raises fail flag past pulse limit.
// RULE7 - Programming zero to one fails eventually.
// RULE8 - Window bit zero while acceptance timer runs.
// RULE9 - Each added sector erase restarts timer.
// RULE10 - Chip erase uses no acceptance timer.
// RULE11 - Skip window check only under 50us spacing.
// RULE12 - Window set: only suspend accepted.
// RULE13 - Window clear: extra sectors accepted.
// RULE14 - Check window before and after added erase.
// RULE15 - Window high afterwards: command maybe rejected; code flags it only if the window was low before the write.
// RULE16 - Status reads use a valid address.
// RULE17 - Erase status pattern defined by device.
// RULE18 - Suspend status pattern defined by device.
// RULE19 - Program keeps fail low, busy pin low.
// RULE20 - Toggle one bit inverts every busy read.
// RULE21 - Sector toggle only inside erasing sectors.
// RULE22 - Poll bit complements datum while programming.
// RULE23 - Ready pin low while busy.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`default_nettype none
module fws_host #(
   parameter int unsigned ADDR_W = 19
) (
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst,
   input  wire logic [3:0]        i_reg_addr,
   input  wire logic [31:0]       i_reg_wdata,
   input  wire logic              i_reg_wr,
   input  wire logic              i_reg_rd,
   output logic      [31:0]       o_reg_rdata,
   output logic      [ADDR_W-1:0] o_flash_addr,
   output logic      [7:0]        o_flash_dq_out,
   output logic                   o_flash_dq_oe,
   input  wire logic [7:0]        i_flash_dq_in,
   output logic                   o_flash_ce_n,
   output logic                   o_flash_oe_n,
   output logic                   o_flash_we_n,
   input  wire logic              i_ready_busy_pin
);
   localparam int unsigned CNT_W = 16;

   fws_pkg::fws_state_e  state_q;
   fws_pkg::fws_status_s stat_q;
   logic [ADDR_W-1:0]    addr_q;
   logic [7:0]           wdata_q;
   logic [7:0]           first_q;
   logic [7:0]           last_q;
   logic [CNT_W-1:0]     cnt_q;
   logic [CNT_W-1:0]     gap_q;
   logic                 recheck_q;
   logic                 check_q;
   logic                 pre_win_q;
   logic                 rd_go;
   logic                 wr_go;
   logic                 ab_go;
   logic                 ck_go;
   logic                 cnt_end;
   logic [7:0]           tog_diff;

   assign rd_go   = i_reg_wr && i_reg_addr == fws_pkg::ADR_CTRL && i_reg_wdata[fws_pkg::CTRL_POLL];
   assign wr_go   = i_reg_wr && i_reg_addr == fws_pkg::ADR_CTRL && i_reg_wdata[fws_pkg::CTRL_WRITE];
   assign ck_go   = i_reg_wr && i_reg_addr == fws_pkg::ADR_CTRL && i_reg_wdata[fws_pkg::CTRL_CHECK];
   assign ab_go   = i_reg_wr && i_reg_addr == fws_pkg::ADR_CTRL && i_reg_wdata[fws_pkg::CTRL_ABORT];
   assign cnt_end = cnt_q == '0;
   assign tog_diff = first_q ^ i_flash_dq_in;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         addr_q  <= '0;
         wdata_q <= '0;
      end else if (i_reg_wr && i_reg_addr == fws_pkg::ADR_ADDR) begin
         addr_q <= i_reg_wdata[ADDR_W-1:0]; // RULE16
      end else if (i_reg_wr && i_reg_addr == fws_pkg::ADR_WDATA) begin
         wdata_q <= i_reg_wdata[7:0];
      end
   end

   // Spacing since the last command write, so software can tell whether skipping the window check is safe.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         gap_q <= '0;
      end else if (state_q == fws_pkg::FWS_WRITE && cnt_end) begin
         gap_q <= '0;
      end else if (gap_q != CNT_W'(fws_pkg::ERASE_GAP_CYCLES)) begin
         gap_q <= gap_q + 1'b1; // RULE11
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_q        <= fws_pkg::FWS_IDLE;
         cnt_q          <= '0;
         first_q        <= '0;
         last_q         <= '0;
         recheck_q      <= 1'b0;
         check_q        <= 1'b0;
         pre_win_q      <= 1'b0;
         stat_q         <= '0;
         o_flash_addr   <= '0;
         o_flash_dq_out <= '0;
         o_flash_dq_oe  <= 1'b0;
         o_flash_ce_n   <= 1'b1;
         o_flash_oe_n   <= 1'b1;
         o_flash_we_n   <= 1'b1;
      end else begin
         stat_q.ready_pin <= i_ready_busy_pin; // RULE23
         unique case (state_q)
            fws_pkg::FWS_IDLE: begin
               if (rd_go || ck_go) begin
                  // A new poll always starts with a fresh pair of reads.
                  state_q        <= fws_pkg::FWS_READ1; // RULE5
                  recheck_q      <= 1'b0;
                  check_q        <= ck_go;
                  stat_q.busy    <= 1'b1;
                  stat_q.done    <= 1'b0;
                  stat_q.fail    <= 1'b0;
                  cnt_q          <= CNT_W'(fws_pkg::RD_CYCLES);
                  o_flash_addr   <= addr_q; // RULE16
                  o_flash_ce_n   <= 1'b0;
                  o_flash_oe_n   <= 1'b0;
               end else if (wr_go) begin
                  state_q        <= fws_pkg::FWS_WRITE;
                  stat_q.busy    <= 1'b1;
                  pre_win_q      <= stat_q.window; // RULE14
                  cnt_q          <= CNT_W'(fws_pkg::WR_CYCLES);
                  o_flash_addr   <= addr_q;
                  o_flash_dq_out <= wdata_q;
                  o_flash_dq_oe  <= 1'b1;
                  o_flash_ce_n   <= 1'b0;
                  o_flash_we_n   <= 1'b0;
               end
            end
            fws_pkg::FWS_WRITE, fws_pkg::FWS_RST: begin
               if (cnt_end) begin
                  state_q       <= fws_pkg::FWS_IDLE;
                  stat_q.busy   <= 1'b0;
                  o_flash_dq_oe <= 1'b0;
                  o_flash_ce_n  <= 1'b1;
                  o_flash_we_n  <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            default: begin
               if (ab_go) begin
                  state_q      <= fws_pkg::FWS_IDLE;
                  stat_q.busy  <= 1'b0;
                  o_flash_ce_n <= 1'b1;
                  o_flash_oe_n <= 1'b1;
               end else if (!cnt_end) begin
                  cnt_q <= cnt_q - 1'b1;
               end else begin
                  // Deassert OE between reads so each sample is a separate device read cycle.
                  o_flash_oe_n <= ~o_flash_oe_n;
                  cnt_q        <= CNT_W'(fws_pkg::RD_CYCLES);
                  if (!o_flash_oe_n) begin
                     last_q <= i_flash_dq_in;
                     if (state_q == fws_pkg::FWS_READ1) begin
                        first_q <= i_flash_dq_in; // RULE1
                        state_q <= fws_pkg::FWS_READ2;
                     end else if (!tog_diff[fws_pkg::BIT_TOG1]) begin
                        state_q      <= fws_pkg::FWS_READ3; // RULE2
                        stat_q.done  <= 1'b1;
                        stat_q.fail  <= 1'b0;
                     end else if (check_q) begin
                        state_q       <= fws_pkg::FWS_IDLE;
                        stat_q.busy   <= 1'b0;
                        stat_q.window <= i_flash_dq_in[fws_pkg::BIT_WIN]; // RULE8
                        stat_q.maybe_rejected <= pre_win_q == 1'b0 && i_flash_dq_in[fws_pkg::BIT_WIN]; // RULE15
                        o_flash_ce_n  <= 1'b1;
                     end else if (recheck_q) begin
                        state_q        <= fws_pkg::FWS_RST; // RULE4
                        stat_q.fail    <= 1'b1;
                        cnt_q          <= CNT_W'(fws_pkg::WR_CYCLES);
                        o_flash_dq_out <= fws_pkg::RESET_CMD;
                        o_flash_dq_oe  <= 1'b1;
                        o_flash_oe_n   <= 1'b1;
                        o_flash_we_n   <= 1'b0;
                     end else if (i_flash_dq_in[fws_pkg::BIT_FAIL]) begin
                        recheck_q <= 1'b1; // RULE3
                        first_q   <= i_flash_dq_in;
                     end else begin
                        first_q <= i_flash_dq_in;
                     end
                  end else if (state_q == fws_pkg::FWS_READ3) begin
                     state_q      <= fws_pkg::FWS_IDLE;
                     stat_q.busy  <= 1'b0;
                     o_flash_ce_n <= 1'b1;
                     o_flash_oe_n <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata <= '0;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            fws_pkg::ADR_ADDR:   o_reg_rdata <= 32'(addr_q);
            fws_pkg::ADR_WDATA:  o_reg_rdata <= {24'h00_0000, wdata_q};
            fws_pkg::ADR_STATUS: o_reg_rdata <= {24'h00_0000, gap_q == CNT_W'(fws_pkg::ERASE_GAP_CYCLES),
                                                 1'b0, stat_q};
            fws_pkg::ADR_RDATA:  o_reg_rdata <= {24'h00_0000, last_q};
            default:             o_reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         o_reg_rdata <= 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

//--- rtl/fws_pkg.sv
`default_nettype none
package fws_pkg;
   localparam int unsigned CLK_MHZ          = 125;
   localparam int unsigned RD_CYCLE_NS      = 90;
   localparam int unsigned RD_CYCLES        = (RD_CYCLE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned WR_PULSE_NS      = 45;
   localparam int unsigned WR_CYCLES        = (WR_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned ERASE_GAP_US     = 50;
   localparam int unsigned ERASE_GAP_CYCLES = (ERASE_GAP_US * CLK_MHZ) - 1;

   localparam logic [3:0] ADR_CTRL   = 4'h0;
   localparam logic [3:0] ADR_ADDR   = 4'h1;
   localparam logic [3:0] ADR_WDATA  = 4'h2;
   localparam logic [3:0] ADR_STATUS = 4'h3;
   localparam logic [3:0] ADR_RDATA  = 4'h4;

   localparam int unsigned CTRL_POLL  = 0;
   localparam int unsigned CTRL_WRITE = 1;
   localparam int unsigned CTRL_CHECK = 2;
   localparam int unsigned CTRL_ABORT = 3;

   localparam int unsigned BIT_POLL  = 7;
   localparam int unsigned BIT_TOG1  = 6;
   localparam int unsigned BIT_FAIL  = 5;
   localparam int unsigned BIT_WIN   = 3;
   localparam int unsigned BIT_TOG2  = 2;

   localparam logic [7:0] RESET_CMD = 8'hF0;

   typedef enum logic [2:0] {
      FWS_IDLE  = 3'b000,
      FWS_READ1 = 3'b001,
      FWS_READ2 = 3'b010,
      FWS_READ3 = 3'b011,
      FWS_WRITE = 3'b100,
      FWS_RST   = 3'b101
   } fws_state_e;

   typedef struct packed {
      logic       busy;
      logic       done;
      logic       fail;
      logic       window;
      logic       maybe_rejected;
      logic       ready_pin;
   } fws_status_s;
endpackage
`default_nettype wire

//--- test/fws_flash_model.sv
`default_nettype none
module fws_flash_model (
   input wire logic [7:0] i_dq,
   input wire logic       i_ce_n,
   input wire logic       i_oe_n,
   input wire logic       i_we_n,
   input wire logic       i_erase,
   input wire logic       i_fail,
   input wire logic [3:0] i_reads,
   output logic     [7:0] o_dq,
   output logic           o_rdy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       busy = 1'b0;
   logic       fail = 1'b0;
   logic       tog  = 1'b0;
   logic [3:0] left = 4'h0;
   logic [7:0] last = 8'h00;
   logic [7:0] dout = 8'h00;
   logic       wr_act;
   logic       rd_act;
   // The host holds CE low through a poll and pulses OE or WE within it, so a cycle is taken from the combined enables.
   assign wr_act = !i_ce_n && !i_we_n;
   assign rd_act = !i_ce_n && !i_oe_n;
   assign o_rdy = !busy;
   assign o_dq  = i_oe_n ? ~dout : dout;
   always @(negedge wr_act) begin
      busy = (i_dq != 8'hF0);
      fail = 1'b0;
      left = i_reads;
      if (busy) last = i_dq;
   end
   always @(posedge rd_act) begin
      if (busy) begin
         tog = !tog;
         if (left != 4'h0) left = left - 4'h1;
         else if (i_fail) fail = 1'b1;
         else busy = 1'b0;
         dout = {i_erase ? 1'b0 : ~last[7], tog, fail, 1'b0, i_erase, i_erase & tog, 2'b00};
      end else dout = last;
   end
endmodule
`default_nettype wire

//--- test/fws_host_monitor.sv
`default_nettype none
module fws_host_monitor #(
   parameter int unsigned ADDR_W = 19
) (
   input wire logic              i_clk_sys,
   input wire logic              i_rst,
   input wire logic              i_reg_rd,
   input wire logic [31:0]       o_reg_rdata,
   input wire logic [ADDR_W-1:0] o_flash_addr,
   input wire logic              o_flash_dq_oe,
   input wire logic              o_flash_ce_n,
   input wire logic              o_flash_oe_n,
   input wire logic              o_flash_we_n
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   property p_rd_idle; !$past(i_reg_rd) |-> o_reg_rdata == 32'h0000_0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read slot");
   property p_no_clash; !(!o_flash_oe_n && !o_flash_we_n); endproperty
   a_no_clash: assert property (p_no_clash) else $error("read and write strobes low together");
   property p_rd_hold; $fell(o_flash_oe_n) |-> !o_flash_oe_n [*8]; endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read strobe too short");
   property p_wr_hold; $fell(o_flash_we_n) |-> !o_flash_we_n [*6]; endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write strobe too short");
   property p_wr_drive; !o_flash_we_n |-> o_flash_dq_oe; endproperty
   a_wr_drive: assert property (p_wr_drive) else $error("write without driving data");
   property p_no_fight; o_flash_dq_oe |-> o_flash_oe_n; endproperty
   a_no_fight: assert property (p_no_fight) else $error("host drives data during read");
   property p_ce_rd; !o_flash_oe_n || !o_flash_we_n |-> !o_flash_ce_n; endproperty
   a_ce_rd: assert property (p_ce_rd) else $error("strobe without chip select");
   property p_addr_hold; !o_flash_oe_n && $past(!o_flash_oe_n) |-> $stable(o_flash_addr); endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved in read");
endmodule
bind fws_host fws_host_monitor #(.ADDR_W(ADDR_W)) u_mon (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
   .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_flash_addr(o_flash_addr), .o_flash_dq_oe(o_flash_dq_oe),
   .o_flash_ce_n(o_flash_ce_n), .o_flash_oe_n(o_flash_oe_n), .o_flash_we_n(o_flash_we_n));
`default_nettype wire

//--- test/test_fws_host.sv
`default_nettype none
module test_fws_host;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk_sys = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, oe, ce_n, oe_n, we_n, rdy;
   logic [3:0] i_reg_addr = 4'h0, nreads = 4'h3;
   logic [31:0] i_reg_wdata = 32'h0000_0000, rdata, rv;
   logic [18:0] addr;
   logic [7:0] dq_out, dq_in, byte_v;
   logic erase = 1'b0, fail = 1'b0;
   int miscompares = 0, checks = 0, cycles = 0;
   always #4 i_clk_sys = !i_clk_sys;
   fws_host DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(rdata), .o_flash_addr(addr), .o_flash_dq_out(dq_out),
      .o_flash_dq_oe(oe), .i_flash_dq_in(dq_in), .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n), .o_flash_we_n(we_n),
      .i_ready_busy_pin(rdy));
   fws_flash_model u_flash (.i_dq(dq_out), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_erase(erase),
      .i_fail(fail), .i_reads(nreads), .o_dq(dq_in), .o_rdy(rdy));
   task automatic test_done();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge i_clk_sys) if (++cycles > 60000) begin
      miscompares++;
      test_done();
   end
   task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge i_clk_sys);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_reg_rd <= 1'b0;
      #1 rv = rdata;
   endtask
   task automatic run(input int bit_no);
      wr(fws_pkg::ADR_CTRL, 32'h1 << bit_no);
      for (int n = 0; n < 3000; n++) begin
         rd(fws_pkg::ADR_STATUS);
         if (rv[5] === 1'b0) break;
      end
   endtask
   initial begin
      void'($urandom(32'h4808));
      repeat (5) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      for (int t = 0; t < 8; t++) begin
         byte_v = 8'($urandom);
         if (byte_v == 8'hF0) byte_v = 8'h0F;
         @(posedge i_clk_sys);
         erase <= t[0];
         fail <= (t == 3 || t == 6);
         nreads <= 4'(3 + $urandom % 6);
         wr(fws_pkg::ADR_ADDR, 32'($urandom % 524288));
         wr(fws_pkg::ADR_WDATA, {24'h0, byte_v});
         run(fws_pkg::CTRL_WRITE);
         if (erase) begin
            run(fws_pkg::CTRL_CHECK);
            cmp({31'h0, rv[2]}, 32'h1);
         end
         run(fws_pkg::CTRL_POLL);
         cmp({26'h0, rv[5:0] & 6'h39}, {26'h0, 1'b0, !fail, fail, 3'b001});
         if (!fail) begin
            rd(fws_pkg::ADR_RDATA);
            cmp(rv, {24'h0, byte_v});
         end
         $display("test %0d ended", t);
      end
      test_done();
   end
endmodule
`default_nettype wire
